// ==== fpc_ctrl.sv ====
// Host controller that drives a parallel flash through its pins.
// Assumes synchronous pin inputs and a software master on AXI4-Lite.
//
// Notes on behaviour
// - ID read: line nine qualifier; select, output enable, lines six, one low.
// - Protect check: line nine qualifier, write enable, line one high; answer 01H/00H.
// - Host locks region by enter sequence then protect algorithm.
// - Host issues exit sequence before touching the rest of the array.
// - Host writes only with select and write enable low, output enable high.
// - Address taken on later falling edge, data on earlier rising edge.
`timescale 1ns/1ps
`include "fpc_consts.svh"

module fpc_ctrl (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address, data and response
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Flash pins
   output fpc_pkg::fpc_pins_t     flash_pins,
   input  wire logic [15:0]       flash_dq_in,
   output logic [15:0]            flash_dq_out,
   output logic                   flash_dq_oe
);
   import fpc_pkg::*;

   // --------------------------------------------------------------
   // Sequencer types and state
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      FPC_ST_IDLE,
      FPC_ST_SETUP,
      FPC_ST_STROBE,
      FPC_ST_HOLD,
      FPC_ST_NEXT
   } fpc_state_t;

   fpc_state_t   state_r;
   fpc_op_t      op_r;
   logic [21:0]  addr_r;
   logic [15:0]  wdata_r;
   logic [15:0]  rdata_r;
   logic [2:0]   step_r;
   logic [2:0]   nsteps_r;
   logic [7:0]   cnt_r;
   logic         rst_hv_r;
   logic         done_r;
   logic         lockbit_r;
   logic         aw_ok_r;
   logic         w_ok_r;
   logic [7:0]   awaddr_r;
   logic [31:0]  wword_r;
   logic         bvalid_r;
   logic         rvalid_r;
   logic [31:0]  rdata_bus_r;
   fpc_pins_t    pins_r;
   logic         dq_oe_r;
   logic [15:0]  dq_out_r;

   // --------------------------------------------------------------
   // Cycle selection: per step, address, data and read or write
   // --------------------------------------------------------------
   function automatic logic [21:0] step_addr(input fpc_op_t op, input logic [2:0] st,
                                             input logic [21:0] a);
      if (st == 3'h0 || st == 3'h2)
         step_addr = `FPC_UNLOCK1_ADDR;
      else if (st == 3'h1)
         step_addr = `FPC_UNLOCK2_ADDR;
      else
         step_addr = a;
   endfunction

   function automatic logic [15:0] step_data(input fpc_op_t op, input logic [2:0] st,
                                             input logic [15:0] d);
      step_data = d;
      if (st == 3'h0)
         step_data = `FPC_UNLOCK1_DATA;
      else if (st == 3'h1)
         step_data = `FPC_UNLOCK2_DATA;
      else if (st == 3'h2) begin
         unique case (op)
            FPC_OP_ENTER_SEC: step_data = `FPC_CMD_ENTER;
            FPC_OP_PROG:      step_data = `FPC_CMD_PROG;
            default:          step_data = `FPC_CMD_AUTOSEL;
         endcase
      end else if (op == FPC_OP_EXIT_SEC)
         step_data = `FPC_CMD_EXIT;
   endfunction

   // Plain one-cycle operations bypass the unlock prefix.
   wire single_op  = (op_r == FPC_OP_READ) || (op_r == FPC_OP_WRITE) ||
                     (op_r == FPC_OP_ID_READ) || (op_r == FPC_OP_PROT_CHK) ||
                     (op_r == FPC_OP_RESET_CMD);
   wire hv_op      = (op_r == FPC_OP_ID_READ) || (op_r == FPC_OP_PROT_CHK);
   wire is_read    = (op_r == FPC_OP_READ) || hv_op;
   wire [21:0] cyc_addr = single_op ? addr_r : step_addr(op_r, step_r, addr_r);
   wire [15:0] cyc_data = (op_r == FPC_OP_RESET_CMD) ? `FPC_CMD_RESET :
                          single_op ? wdata_r : step_data(op_r, step_r, wdata_r);
   wire phase_end  = (cnt_r == 8'(`FPC_PHASE_CYC - 1));
   wire last_step  = (step_r == nsteps_r);

   // Hardware-mode address: line six low, line one low for ID and high for check.
   wire [21:0] hv_addr = (op_r == FPC_OP_ID_READ) ?
                         {addr_r[21:7], 1'b0, addr_r[5:2], 1'b0, addr_r[0]} :
                         {addr_r[21:16], 9'h000, 1'b0, 4'h0, 1'b1, 1'b0};

   // --------------------------------------------------------------
   // AXI4-Lite slave
   // --------------------------------------------------------------
   wire busy     = (state_r != FPC_ST_IDLE);
   wire wr_fire  = aw_ok_r && w_ok_r && !bvalid_r;
   wire ofs_ctrl = (awaddr_r == `FPC_OFS_CTRL);
   wire go       = wr_fire && ofs_ctrl && wword_r[`FPC_CTRL_GO] && !busy;
   // Operation being written now; op_r only takes it at the same edge as go.
   fpc_op_t go_op;
   assign go_op = fpc_op_t'(wword_r[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB]);
   wire [31:0] rd_mux =
      (s_axi_araddr == `FPC_OFS_CTRL)   ? {26'h0, 1'b0, rst_hv_r, op_r, 1'b0} :
      (s_axi_araddr == `FPC_OFS_ADDR)   ? {10'h0, addr_r} :
      (s_axi_araddr == `FPC_OFS_WDATA)  ? {16'h0, wdata_r} :
      (s_axi_araddr == `FPC_OFS_STATUS) ? {29'h0, lockbit_r, done_r, busy} :
      (s_axi_araddr == `FPC_OFS_RDATA)  ? {16'h0, rdata_r} : 32'h0;
   wire rd_ok = (s_axi_araddr == `FPC_OFS_CTRL) || (s_axi_araddr == `FPC_OFS_ADDR) ||
                (s_axi_araddr == `FPC_OFS_WDATA) || (s_axi_araddr == `FPC_OFS_STATUS) ||
                (s_axi_araddr == `FPC_OFS_RDATA);
   wire wr_ok = (awaddr_r <= `FPC_OFS_RDATA) && (awaddr_r[1:0] == 2'h0);

   assign s_axi_awready = !aw_ok_r && !bvalid_r;
   assign s_axi_wready  = !w_ok_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_bus_r;
   assign s_axi_rresp   = 2'h0;

   // Write channel capture and response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r  <= 1'b0;
         w_ok_r   <= 1'b0;
         bvalid_r <= 1'b0;
         awaddr_r <= 8'h00;
         wword_r  <= 32'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r  <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r  <= 1'b1;
            wword_r <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_ok_r  <= 1'b0;
            w_ok_r   <= 1'b0;
            bvalid_r <= 1'b1;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel: answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r    <= 1'b0;
         rdata_bus_r <= 32'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r    <= 1'b1;
         rdata_bus_r <= rd_ok ? rd_mux : 32'h0;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Software registers; writes are ignored while a sequence runs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_r     <= FPC_OP_READ;
         addr_r   <= 22'h0;
         wdata_r  <= 16'h0;
         rst_hv_r <= 1'b0;
      end else if (wr_fire && wr_ok && !busy && s_axi_wstrb != 4'h0) begin
         unique case (awaddr_r)
            `FPC_OFS_CTRL: begin
               op_r     <= fpc_op_t'(wword_r[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB]);
               rst_hv_r <= wword_r[`FPC_CTRL_RSTHV];
            end
            `FPC_OFS_ADDR:  addr_r  <= wword_r[21:0];
            `FPC_OFS_WDATA: wdata_r <= wword_r[15:0];
            default: ;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Flash bus sequencer: setup, strobe, hold for each bus cycle
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= FPC_ST_IDLE;
         step_r    <= 3'h0;
         nsteps_r  <= 3'h0;
         cnt_r     <= 8'h00;
         done_r    <= 1'b0;
         rdata_r   <= 16'h0;
         lockbit_r <= 1'b0;
      end else begin
         unique case (state_r)
            FPC_ST_IDLE: if (go) begin
               done_r   <= 1'b0;
               step_r   <= 3'h0;
               cnt_r    <= 8'h00;
               // Enter uses three cycles, others with prefix use four.
               nsteps_r <= (go_op == FPC_OP_ENTER_SEC) ? 3'h2 :
                           (go_op == FPC_OP_EXIT_SEC || go_op == FPC_OP_PROG) ? 3'h3 :
                           3'h0;
               state_r  <= FPC_ST_SETUP;
            end
            FPC_ST_SETUP: begin
               cnt_r <= phase_end ? 8'h00 : cnt_r + 8'h01;
               if (phase_end) state_r <= FPC_ST_STROBE;
            end
            FPC_ST_STROBE: begin
               // Strobe held for many cycles, far beyond the glitch filter.
               cnt_r <= phase_end ? 8'h00 : cnt_r + 8'h01;
               if (phase_end && is_read) begin
                  rdata_r   <= flash_dq_in;
                  lockbit_r <= flash_dq_in[7];
               end
               if (phase_end) state_r <= FPC_ST_HOLD;
            end
            FPC_ST_HOLD: begin
               cnt_r <= phase_end ? 8'h00 : cnt_r + 8'h01;
               if (phase_end) state_r <= FPC_ST_NEXT;
            end
            FPC_ST_NEXT: begin
               if (last_step) begin
                  state_r <= FPC_ST_IDLE;
                  done_r  <= 1'b1;
               end else begin
                  step_r  <= step_r + 3'h1;
                  state_r <= FPC_ST_SETUP;
               end
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // Pin drive: address steady through the strobe, data past it
   // --------------------------------------------------------------
   wire strobe = (state_r == FPC_ST_STROBE);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_r   <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
                       reset_n: 1'b0, reset_hv: 1'b0, addr_line_nine_hv: 1'b0, addr: 22'h0};
         dq_oe_r  <= 1'b0;
         dq_out_r <= 16'h0;
      end else begin
         pins_r.reset_n  <= 1'b1;
         pins_r.reset_hv <= rst_hv_r;
         pins_r.addr_line_nine_hv <= busy && hv_op;
         pins_r.addr     <= hv_op ? hv_addr : cyc_addr;
         pins_r.chip_sel_n <= !(busy && (state_r != FPC_ST_NEXT));
         // Reads: output enable low; protect check holds write enable high.
         pins_r.out_en_n <= !(strobe && is_read);
         pins_r.wr_en_n  <= !(strobe && !is_read);
         dq_oe_r         <= busy && !is_read && (state_r != FPC_ST_NEXT);
         dq_out_r        <= cyc_data;
      end
   end

   assign flash_pins   = pins_r;
   assign flash_dq_oe  = dq_oe_r;
   assign flash_dq_out = dq_out_r;

endmodule // fpc_ctrl

// ==== fpc_consts.svh ====
// Constants for the flash protect/secured-region host controller.
// Assumes inclusion by the package, the controller and the bench.
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define FPC_OFS_CTRL     8'h00
`define FPC_OFS_ADDR     8'h04
`define FPC_OFS_WDATA    8'h08
`define FPC_OFS_STATUS   8'h0C
`define FPC_OFS_RDATA    8'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FPC_CTRL_GO      0
`define FPC_CTRL_OP_LSB  1
`define FPC_CTRL_OP_MSB  3
`define FPC_CTRL_RSTHV   4
`define FPC_CTRL_WORD    5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define FPC_ST_BUSY      0
`define FPC_ST_DONE      1
`define FPC_ST_LOCKBIT   2

// ----------------------------------------------------------------
// Command sequence values
// ----------------------------------------------------------------
`define FPC_UNLOCK1_ADDR 22'h000555
`define FPC_UNLOCK2_ADDR 22'h0002AA
`define FPC_UNLOCK1_DATA 16'h00AA
`define FPC_UNLOCK2_DATA 16'h0055
`define FPC_CMD_ENTER    16'h0088
`define FPC_CMD_AUTOSEL  16'h0090
`define FPC_CMD_EXIT     16'h0000
`define FPC_CMD_RESET    16'h00F0
`define FPC_CMD_PROG     16'h00A0

// ----------------------------------------------------------------
// Timing: each pin phase lasts long enough to beat the glitch filter
// ----------------------------------------------------------------
`define FPC_CLK_NS       4
`define FPC_GLITCH_NS    5
`define FPC_PHASE_NS     40
`define FPC_PHASE_CYC    ((`FPC_PHASE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_GLITCH_CYC   ((`FPC_GLITCH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

// ==== fpc_pkg.sv ====
// Types for the flash protect/secured-region host controller.
// Assumes the constants header sits in the same folder.
`include "fpc_consts.svh"
package fpc_pkg;

   // -------------------------------------------------------------
   // Operations the controller can run on the flash
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      FPC_OP_READ,
      FPC_OP_WRITE,
      FPC_OP_ID_READ,
      FPC_OP_PROT_CHK,
      FPC_OP_ENTER_SEC,
      FPC_OP_EXIT_SEC,
      FPC_OP_RESET_CMD,
      FPC_OP_PROG
   } fpc_op_t;

   // Flash control and address pins driven by the controller.
   typedef struct packed {
      logic        chip_sel_n;
      logic        out_en_n;
      logic        wr_en_n;
      logic        reset_n;
      logic        reset_hv;
      logic        addr_line_nine_hv;
      logic [21:0] addr;
   } fpc_pins_t;

   // AXI4-Lite request bundles.
   typedef struct packed {
      logic [7:0]  addr;
      logic        valid;
   } fpc_ax_t;

endpackage

// ==== fpc_ctrl_props.sv ====
// Checker of the flash pin discipline kept by the host controller.
// Assumes it is bound into fpc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module fpc_ctrl_props (
   // Clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   // Flash pins
   input wire fpc_pkg::fpc_pins_t flash_pins,
   input wire logic [15:0]        flash_dq_out,
   input wire logic               flash_dq_oe
);
   import fpc_pkg::*;
   // Short names for the watched pins.
   wire        cs_n = flash_pins.chip_sel_n;
   wire        oe_n = flash_pins.out_en_n;
   wire        we_n = flash_pins.wr_en_n;
   wire        hv9  = flash_pins.addr_line_nine_hv;
   wire [21:0] ad   = flash_pins.addr;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Relations that every flash bus cycle must keep.
   wr_inhibit_a: assert property (!we_n |-> !cs_n && oe_n)
      else $error("write strobe without select or with output enable");
   no_contend_a: assert property (flash_dq_oe |-> oe_n)
      else $error("data driven while flash outputs are enabled");
   id_pins_a: assert property (
      hv9 && !oe_n && !ad[1] |-> !cs_n && we_n && !ad[6])
      else $error("identifier read with wrong pin levels");
   prot_pins_a: assert property (
      hv9 && !oe_n && ad[1] |-> !cs_n && we_n && !ad[6] && !ad[0])
      else $error("protect check with wrong pin levels");
   addr_hold_a: assert property (
      !we_n |-> $stable(ad) && $stable(flash_dq_out))
      else $error("address or data moved during write strobe");
   data_edge_a: assert property (
      $rose(we_n) |=> flash_dq_oe && $stable(flash_dq_out))
      else $error("data not held after write strobe");
   strobe_len_a: assert property ($fell(we_n) |-> !we_n [*8])
      else $error("write strobe too short");
   sel_first_a: assert property ($fell(cs_n) |-> we_n && oe_n)
      else $error("select fell together with a strobe");
   rd_strobe_a: assert property ($fell(oe_n) |-> (!cs_n && we_n) [*8])
      else $error("read strobe too short or unselected");
   hv_reset_a: assert property (flash_pins.reset_hv |-> flash_pins.reset_n)
      else $error("reset pin qualifier raised while reset held");
   // Main scenarios reached.
   id_c:   cover property (hv9 && !oe_n && !ad[1]);
   prot_c: cover property (hv9 && !oe_n && ad[1]);
   prog_c: cover property ($fell(we_n) && flash_pins.reset_hv);
endmodule // fpc_ctrl_props
bind fpc_ctrl fpc_ctrl_props u_props (
   .aclk         (aclk),
   .aresetn      (aresetn),
   .flash_pins   (flash_pins),
   .flash_dq_out (flash_dq_out),
   .flash_dq_oe  (flash_dq_oe)
);

// ==== fpc_flash_model.sv ====
// Behavioural model of the parallel flash as seen at its pins.
// Assumes the bench resolves the shared data bus and feeds it back.
`timescale 1ns/1ps
module fpc_flash_model
   import fpc_pkg::*;
#(
   parameter logic [15:0] MAKER_ID  = 16'h005A, // Arbitrary value.
   parameter logic [15:0] PART_ID   = 16'h0033, // Arbitrary value.
   parameter logic        FACT_LOCK = 1'h1
) (
   // Pins and bus level; qualifiers are plain inputs
   input  wire fpc_pkg::fpc_pins_t pins,
   input  wire logic [15:0]        bus_dq,
   // Data the flash offers
   output logic [15:0]             dev_dq
);
   logic [15:0] mem_r [16];
   logic [21:0] adr_r;
   logic [2:0]  st_r;
   logic        sec_r;
   logic [15:0] last_r;
   realtime     t_fall_r;
   localparam realtime GLITCH_NS = 5.0;
   wire         cs_n  = pins.chip_sel_n;
   wire         we_n  = pins.wr_en_n;
   wire         oe_n  = pins.out_en_n;
   wire         unlk  = adr_r[10:0] == 11'h555;
   wire         drive = !cs_n && !oe_n && pins.reset_n;
   wire [15:0]  rd;
   // Codes, protect status, secured words or array.
   assign rd = pins.addr_line_nine_hv ? (pins.addr[1] ? {15'h0000, pins.addr[16]}
                                          : (pins.addr[0] ? PART_ID : MAKER_ID))
             : (sec_r && pins.addr[21:7] == 15'h0000)
               ? (pins.addr[6:3] == 4'h0 ? {8'h00, FACT_LOCK, 4'h0, pins.addr[2:0]} : 16'hFFFF)
             : mem_r[pins.addr[3:0]];
   // A released bus shows the inverse of the last word, so stale data never passes.
   assign dev_dq = drive ? rd : ~last_r;
   always @(posedge oe_n or posedge cs_n) last_r = rd;
   // Power-up and hardware reset give read mode and normal mapping.
   initial begin
      st_r = 3'h0;
      sec_r = 1'h0;
      last_r = 16'h0000;
      t_fall_r = 0.0;
      foreach (mem_r[i]) mem_r[i] = 16'hFFFF;
   end
   always @(negedge pins.reset_n) begin
      st_r = 3'h0;
      sec_r = 1'h0;
   end
   // Address is taken at the later falling edge.
   always @(negedge we_n or negedge cs_n) begin
      t_fall_r = $realtime;
      if (!we_n && !cs_n && oe_n) adr_r = pins.addr;
   end
   // Data at the first rising edge; stray cycles fall back.
   always @(posedge we_n or posedge cs_n) begin
      // Held reset (power-up, lockout) and short glitches start no write.
      if ((!we_n || !cs_n) && oe_n && pins.reset_n && ($realtime - t_fall_r >= GLITCH_NS)) begin
         case (st_r)
            3'h0: st_r = (unlk && bus_dq == 16'h00AA) ? 3'h1 : 3'h0;
            3'h1: st_r = (adr_r[10:0] == 11'h2AA && bus_dq == 16'h0055) ? 3'h2 : 3'h0;
            3'h2: begin
               st_r = !unlk ? 3'h0 : bus_dq == 16'h0090 ? 3'h3 : bus_dq == 16'h00A0 ? 3'h4 : 3'h0;
               if (unlk && bus_dq == 16'h0088) sec_r = 1'h1;
            end
            3'h3: begin
               if (bus_dq == 16'h0000) sec_r = 1'h0;
               st_r = 3'h0;
            end
            default: begin
               // Locked region never changes; protected groups need the qualifier.
               if (!(sec_r && adr_r[21:7] == 15'h0000) && (!adr_r[16] || pins.reset_hv))
                  mem_r[adr_r[3:0]] = mem_r[adr_r[3:0]] & bus_dq;
               st_r = 3'h0;
            end
         endcase
      end
   end
endmodule // fpc_flash_model

// ==== testbench.sv ====
// Self-checking bench for the flash host controller and its flash model.
// Assumes the package, checker and model files are compiled before it.
`timescale 1ns/1ps
`include "fpc_consts.svh"
module testbench;
   import fpc_pkg::*;
   localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value.
   localparam logic [15:0] PART  = 16'h0033; // Arbitrary value.
   localparam int          LIM   = 2000;
   logic              aclk, aresetn, awvalid, wvalid, arvalid;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic              awready, wready, bvalid, arready, rvalid, dq_oe;
   fpc_pins_t         pins;
   logic [15:0]       dq_ctl, dq_dev;
   logic [1:0]        bresp, rresp;
   wire  [15:0]       dq_bus = dq_oe ? dq_ctl : dq_dev;
   int                n_fail = 0;
   int                compares = 0;
   // Design and flash model.
   fpc_ctrl u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'h1), .flash_pins(pins), .flash_dq_in(dq_bus),
      .flash_dq_out(dq_ctl), .flash_dq_oe(dq_oe));
   fpc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .FACT_LOCK(1'h1)) u_flash (
      .pins(pins), .bus_dq(dq_bus), .dev_dq(dq_dev));
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   // Verdict and shared checking tasks.
   task automatic close_out;
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stall(input int n);
      if (n >= LIM) begin
         n_fail++;
         $display("wrong value at %0t: no answer in time", $time);
         close_out;
      end
   endtask
   // Register bus master tasks.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < LIM);
      stall(n);
      chk(32'(bresp), 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < LIM);
      d = rdata;
      stall(n);
      chk(32'(rresp), 32'h0);
   endtask
   // Starts one flash operation in word mode and waits until it is done.
   task automatic run(input fpc_op_t op, input logic [21:0] a, input logic [15:0] d,
                      input logic hv);
      logic [31:0] st;
      int          n;
      n = 0;
      wr(`FPC_OFS_ADDR, {10'h000, a});
      wr(`FPC_OFS_WDATA, {16'h0000, d});
      wr(`FPC_OFS_CTRL, (32'(op) << `FPC_CTRL_OP_LSB) | (32'(hv) << `FPC_CTRL_RSTHV) | 32'h21);
      do begin
         rd(`FPC_OFS_STATUS, st);
         n++;
      end while (st[`FPC_ST_BUSY] !== 1'h0 && n < LIM);
      stall(n);
      chk(32'(st[`FPC_ST_DONE]), 32'h1);
   endtask
   task automatic peek(input fpc_op_t op, input logic [21:0] a, input logic [15:0] exp);
      logic [31:0] v;
      run(op, a, 16'h0000, 1'h0);
      rd(`FPC_OFS_RDATA, v);
      chk(v, {16'h0000, exp});
   endtask
   // Scenarios.
   task automatic t_ident;
      logic [31:0] v;
      rd(`FPC_OFS_STATUS, v);
      chk(v, 32'h0);
      rd(8'h20, v);
      chk(v, 32'h0);
      peek(FPC_OP_ID_READ, 22'h000000, MAKER);
      peek(FPC_OP_ID_READ, 22'h000001, PART);
      peek(FPC_OP_PROT_CHK, 22'h3F0000, 16'h0001);
      peek(FPC_OP_PROT_CHK, 22'h3E0000, 16'h0000);
   endtask
   task automatic t_prog;
      run(FPC_OP_PROG, 22'h000003, 16'h1234, 1'h0);
      peek(FPC_OP_READ, 22'h000003, 16'h1234);
      run(FPC_OP_WRITE, 22'h000555, 16'h00AA, 1'h0);
      run(FPC_OP_WRITE, 22'h000003, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h000003, 16'h1234);
      run(FPC_OP_RESET_CMD, 22'h000003, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h000003, 16'h1234);
      run(FPC_OP_PROG, 22'h010005, 16'h5A5A, 1'h1);
      peek(FPC_OP_READ, 22'h010005, 16'h5A5A);
      run(FPC_OP_PROG, 22'h010005, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h010005, 16'h5A5A);
   endtask
   task automatic t_secure;
      logic [31:0] st;
      run(FPC_OP_ENTER_SEC, 22'h000000, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h000002, 16'h0082);
      rd(`FPC_OFS_STATUS, st);
      chk(32'(st[`FPC_ST_LOCKBIT]), 32'h1);
      run(FPC_OP_PROG, 22'h000002, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h000002, 16'h0082);
      peek(FPC_OP_READ, 22'h000040, 16'hFFFF);
      run(FPC_OP_EXIT_SEC, 22'h000000, 16'h0000, 1'h0);
      peek(FPC_OP_READ, 22'h000003, 16'h1234);
      run(FPC_OP_ENTER_SEC, 22'h000000, 16'h0000, 1'h0);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`FPC_OFS_STATUS, st);
      chk(st, 32'h0);
      peek(FPC_OP_READ, 22'h000002, 16'hFFFF);
   endtask
   initial begin
      aresetn = 1'h0;
      {awvalid, wvalid, arvalid} = 3'h0;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_ident;
      t_prog;
      t_secure;
      close_out;
   end
endmodule // testbench
